// ### tad_pkg.sv
package tad_pkg;

  // Bus widths.
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam int REGION_N = 4;

  // Address bits that choose a region in each map.
  localparam int MEM_HI_BIT = 15;
  localparam int MEM_LO_BIT = 14;
  localparam int IO_HI_BIT = 7;
  localparam int IO_LO_BIT = 6;

  // Memory decoder outputs, each 16K wide in the normal map.
  localparam int MEM_RGN_EPROM = 0;
  localparam int MEM_RGN_SRAM_LO = 1;
  localparam int MEM_RGN_SRAM_HI = 2;
  localparam int MEM_RGN_COMBO = 3;

  // I/O decoder outputs, each 64 ports wide.
  localparam int IO_RGN_COMBO = 0;
  localparam int IO_RGN_KEYPAD = 1;
  localparam int IO_RGN_SERIAL = 2;
  localparam int IO_RGN_EXPAN = 3;

  // Reset values.
  localparam logic [ADDR_W-1:0] RESET_VECTOR = 16'h0000;
  localparam logic [BYTE_W-1:0] LATCH_RST = 8'h00;
  localparam logic [BYTE_W-1:0] IDLE_BUS_LEVEL = 8'hff;

  // Processor timing: T-state rate against the design clock.
  localparam longint CLK_HZ = 200000000;
  localparam longint SYSTEM_CLOCK_OUT_HZ = 3072000;
  localparam int HALF_T_CYC = int'(CLK_HZ / (2 * SYSTEM_CLOCK_OUT_HZ));
  localparam int CYCLE_T_MIN = 3;
  localparam int CYCLE_T_MAX = 14;

  typedef enum {
    st_idle,
    st_t1,
    st_t2,
    st_t3
  } tad_bus_state_t;

endpackage

// ### tad_bus_if.sv
interface tad_bus_if;

  // Processor drive of the shared low address/data lines.
  logic [tad_pkg::BYTE_W-1:0] ad_out;
  logic ad_oe_n;
  // Memory or I/O chip drive of the same lines, left to the bench.
  logic [tad_pkg::BYTE_W-1:0] ext_data;
  logic ext_oe_n;
  // Resolved level of the shared lines; undriven lines float high.
  logic [tad_pkg::BYTE_W-1:0] muxed_addr_data;

  logic [tad_pkg::BYTE_W-1:0] high_addr_byte;
  logic ale;
  logic rd_n;
  logic wr_n;
  logic io_m;
  logic system_clock_out;

  assign muxed_addr_data = !ad_oe_n ? ad_out :
                           (!ext_oe_n ? ext_data : tad_pkg::IDLE_BUS_LEVEL);

  modport cpu (
    output ad_out,
    output ad_oe_n,
    output high_addr_byte,
    output ale,
    output rd_n,
    output wr_n,
    output io_m,
    output system_clock_out,
    input muxed_addr_data
  );

  modport dec (
    input muxed_addr_data,
    input high_addr_byte,
    input ale,
    input rd_n,
    input wr_n,
    input io_m,
    input system_clock_out
  );

endinterface

// ### tad_cpu_end.sv
module tad_cpu_end (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Transfer requests.
  input wire logic i_req,
  input wire logic i_io,
  input wire logic i_write,
  input wire logic [tad_pkg::ADDR_W-1:0] i_addr,
  input wire logic [tad_pkg::BYTE_W-1:0] i_wdata,
  // Transfer results.
  output logic o_ready,
  output logic o_done,
  output logic [tad_pkg::BYTE_W-1:0] o_rdata,
  // Processor bus.
  tad_bus_if.cpu bus
);

  localparam int CNT_W = $clog2(tad_pkg::HALF_T_CYC);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(tad_pkg::HALF_T_CYC - 1);

  logic [CNT_W-1:0] half_cnt_ff;
  logic system_clock_out_ff;
  tad_pkg::tad_bus_state_t state_ff;
  logic pend_ff;
  logic cur_io_ff;
  logic cur_wr_ff;
  logic [tad_pkg::ADDR_W-1:0] cur_addr_ff;
  logic [tad_pkg::BYTE_W-1:0] cur_wdata_ff;
  logic ready_ff;
  logic done_ff;
  logic [tad_pkg::BYTE_W-1:0] rdata_ff;
  logic [tad_pkg::BYTE_W-1:0] ad_out_ff;
  logic ad_oe_n_ff;
  logic [tad_pkg::BYTE_W-1:0] high_ff;
  logic ale_ff;
  logic rd_n_ff;
  logic wr_n_ff;
  logic io_m_ff;

  wire half_tick = (half_cnt_ff == CNT_MAX);
  wire t_edge = half_tick && !system_clock_out_ff;
  wire take_req = i_req && ready_ff;
  wire start = t_edge && (state_ff == tad_pkg::st_idle) && pend_ff;
  wire [tad_pkg::BYTE_W-1:0] addr_lo = cur_addr_ff[tad_pkg::BYTE_W-1:0];
  wire [tad_pkg::BYTE_W-1:0] addr_hi = cur_addr_ff[tad_pkg::ADDR_W-1:tad_pkg::BYTE_W];
  // An I/O port number is shown on both address bytes at once.
  wire [tad_pkg::BYTE_W-1:0] nxt_high = cur_io_ff ? addr_lo : addr_hi;

  // T-state divider; each T-state is one full period of system_clock_out.
  always_ff @(posedge i_clk) begin
    if (i_rst || half_tick) begin
      half_cnt_ff <= '0;
    end else begin
      half_cnt_ff <= half_cnt_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      system_clock_out_ff <= 1'b0;
    end else if (half_tick) begin
      system_clock_out_ff <= !system_clock_out_ff;
    end
  end

  // The reset preloads a read of the reset vector as the first transfer.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pend_ff <= 1'b1;
      cur_io_ff <= 1'b0;
      cur_wr_ff <= 1'b0;
      cur_addr_ff <= tad_pkg::RESET_VECTOR;
      cur_wdata_ff <= tad_pkg::LATCH_RST;
    end else if (take_req) begin
      pend_ff <= 1'b1;
      cur_io_ff <= i_io;
      cur_wr_ff <= i_write;
      cur_addr_ff <= i_addr;
      cur_wdata_ff <= i_wdata;
    end else if (start) begin
      pend_ff <= 1'b0;
    end
  end

  // Bus sequence of three T-states per transfer.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= tad_pkg::st_idle;
    end else if (t_edge) begin
      case (state_ff)
        tad_pkg::st_idle: state_ff <= pend_ff ? tad_pkg::st_t1 : tad_pkg::st_idle;
        tad_pkg::st_t1: state_ff <= tad_pkg::st_t2;
        tad_pkg::st_t2: state_ff <= tad_pkg::st_t3;
        tad_pkg::st_t3: state_ff <= tad_pkg::st_idle;
        default: state_ff <= tad_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ad_out_ff <= tad_pkg::LATCH_RST;
      ad_oe_n_ff <= 1'b1;
      high_ff <= tad_pkg::LATCH_RST;
      ale_ff <= 1'b0;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      io_m_ff <= 1'b0;
    end else if (start) begin
      ad_out_ff <= addr_lo;
      ad_oe_n_ff <= 1'b0;
      high_ff <= nxt_high;
      ale_ff <= 1'b1;
      io_m_ff <= cur_io_ff;
    end else if (t_edge && state_ff == tad_pkg::st_t1) begin
      ale_ff <= 1'b0;
      ad_out_ff <= cur_wdata_ff;
      ad_oe_n_ff <= !cur_wr_ff;
      rd_n_ff <= cur_wr_ff;
      wr_n_ff <= !cur_wr_ff;
    end else if (t_edge && state_ff == tad_pkg::st_t3) begin
      ad_oe_n_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ready_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= tad_pkg::LATCH_RST;
    end else begin
      done_ff <= t_edge && (state_ff == tad_pkg::st_t3);
      if (take_req) begin
        ready_ff <= 1'b0;
      end else if (t_edge && state_ff == tad_pkg::st_t3) begin
        ready_ff <= 1'b1;
        rdata_ff <= cur_wr_ff ? rdata_ff : bus.muxed_addr_data;
      end
    end
  end

  assign o_ready = ready_ff;
  assign o_done = done_ff;
  assign o_rdata = rdata_ff;
  assign bus.ad_out = ad_out_ff;
  assign bus.ad_oe_n = ad_oe_n_ff;
  assign bus.high_addr_byte = high_ff;
  assign bus.ale = ale_ff;
  assign bus.rd_n = rd_n_ff;
  assign bus.wr_n = wr_n_ff;
  assign bus.io_m = io_m_ff;
  assign bus.system_clock_out = system_clock_out_ff;

endmodule

// ### tad_decoder.sv
module tad_decoder (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Board jumper, high for the alternate 32K map.
  input wire logic i_memory_map_jumper,
  // Processor bus.
  tad_bus_if.dec bus,
  // Demultiplexed address to memories, I/O chips and expansion.
  output logic [tad_pkg::ADDR_W-1:0] o_addr,
  output logic o_io_cycle,
  // Chip selects.
  output logic o_eprom_sel_n,
  output logic o_sram_sel_n,
  output logic o_combo_peripheral_select_n,
  output logic o_keypad_sel_n,
  output logic o_serial_sel_n,
  output logic o_expan_io_sel_n,
  // Raw decoder outputs.
  output logic [tad_pkg::REGION_N-1:0] o_mem_region_n,
  output logic [tad_pkg::REGION_N-1:0] o_io_region_n,
  // Jumper setting as the decoder currently uses it.
  output logic o_map_alt
);

  localparam int CODE_W = $clog2(tad_pkg::REGION_N);

  logic [tad_pkg::BYTE_W-1:0] low_addr_ff;
  logic jmp_meta_ff;
  logic jmp_ff;
  logic map_alt_ff;

  // While the strobe is high the latch follows the shared lines;
  // the byte seen in the last high cycle is held once it falls.
  wire [tad_pkg::BYTE_W-1:0] nxt_low_addr = bus.ale ? bus.muxed_addr_data : low_addr_ff;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      low_addr_ff <= tad_pkg::LATCH_RST;
    end else begin
      low_addr_ff <= nxt_low_addr;
    end
  end

  // The jumper is a board pin and is brought in through two flip-flops.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      jmp_meta_ff <= 1'b0;
      jmp_ff <= 1'b0;
    end else begin
      jmp_meta_ff <= i_memory_map_jumper;
      jmp_ff <= jmp_meta_ff;
    end
  end

  // A jumper moved in the middle of an access would hand that access to
  // another chip, so a new map is taken only while both strobes are idle.
  wire strobe_idle = bus.rd_n && bus.wr_n;
  wire nxt_map_alt = strobe_idle ? jmp_ff : map_alt_ff;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      map_alt_ff <= 1'b0;
    end else begin
      map_alt_ff <= nxt_map_alt;
    end
  end

  // Full address: latched low byte beside the live high byte.
  wire [tad_pkg::ADDR_W-1:0] addr = {bus.high_addr_byte, low_addr_ff};

  // Only one of the two decoders is enabled at a time.
  wire io_en = bus.io_m;
  wire mem_en = !bus.io_m;

  // In the alternate map the bit 14 input is tied low, so only
  // regions 0 and 2 can ever be reached, each 32K wide.
  wire a14_eff = map_alt_ff ? 1'b0 : addr[tad_pkg::MEM_LO_BIT];
  wire [CODE_W-1:0] mem_code = {addr[tad_pkg::MEM_HI_BIT], a14_eff};

  // The port number sits on both bytes, so the low byte alone serves.
  wire [CODE_W-1:0] io_code = {addr[tad_pkg::IO_HI_BIT], addr[tad_pkg::IO_LO_BIT]};

  logic [tad_pkg::REGION_N-1:0] mem_rgn_n;
  logic [tad_pkg::REGION_N-1:0] io_rgn_n;

  // Two 2-to-4 decoders with active-low outputs; each one is enabled
  // only for its own kind of transaction.
  genvar g;
  generate
    for (g = 0; g < tad_pkg::REGION_N; g++) begin : g_rgn
      wire mem_hit = (mem_code == CODE_W'(g));
      wire io_hit = (io_code == CODE_W'(g));
      assign mem_rgn_n[g] = !(mem_en && mem_hit);
      assign io_rgn_n[g] = !(io_en && io_hit);
    end
  endgenerate

  // Program storage holds region 0, which contains the reset vector.
  wire eprom_n = mem_rgn_n[tad_pkg::MEM_RGN_EPROM];

  // Negative OR of two 16K selects; in the alternate map region 1
  // never decodes, so the same gate gives 8000-FFFF alone.
  wire sram_n = mem_rgn_n[tad_pkg::MEM_RGN_SRAM_LO]
                && mem_rgn_n[tad_pkg::MEM_RGN_SRAM_HI];

  // Region 3 is unreachable in the alternate map, which drops the
  // peripheral's RAM from the memory map entirely.
  wire combo_mem_n = mem_rgn_n[tad_pkg::MEM_RGN_COMBO];

  // One dual-mapped select; the peripheral latches the low byte
  // itself, so its 256 cells repeat across the 16K region.
  wire combo_n = combo_mem_n && io_rgn_n[tad_pkg::IO_RGN_COMBO];

  wire keypad_n = io_rgn_n[tad_pkg::IO_RGN_KEYPAD];
  wire serial_n = io_rgn_n[tad_pkg::IO_RGN_SERIAL];
  wire expan_n = io_rgn_n[tad_pkg::IO_RGN_EXPAN];

  // Selects follow the address with no clock stage in between.
  assign o_eprom_sel_n = eprom_n;
  assign o_sram_sel_n = sram_n;
  assign o_combo_peripheral_select_n = combo_n;
  assign o_keypad_sel_n = keypad_n;
  assign o_serial_sel_n = serial_n;
  assign o_expan_io_sel_n = expan_n;
  assign o_mem_region_n = mem_rgn_n;
  assign o_io_region_n = io_rgn_n;

  // Every address bit goes on unchanged; the chips decode the rest.
  assign o_addr = addr;
  assign o_io_cycle = io_en;
  assign o_map_alt = map_alt_ff;

endmodule

// ### tad_dec_sva.sv
module tad_dec_sva (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Processor bus.
  input wire logic [7:0] muxed_addr_data,
  input wire logic [7:0] high_addr_byte,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic io_m,
  // Decoder side.
  input wire logic [15:0] o_addr,
  input wire logic o_map_alt,
  input wire logic o_eprom_sel_n,
  input wire logic o_sram_sel_n,
  input wire logic o_combo_peripheral_select_n,
  input wire logic o_keypad_sel_n,
  input wire logic o_serial_sel_n,
  input wire logic o_expan_io_sel_n,
  input wire logic [3:0] o_mem_region_n,
  input wire logic [3:0] o_io_region_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_latch_low_byte: assert property ($past(ale) |-> o_addr[7:0] == $past(muxed_addr_data))
    else $error("latched low byte wrong");
  a_high_pass: assert property (o_addr[15:8] == high_addr_byte)
    else $error("high byte not passed through");
  a_addr_steady: assert property ($fell(rd_n) |-> ##1 $stable(o_addr) [*8])
    else $error("address moved during read strobe");
  a_io_no_mem: assert property (io_m |-> o_mem_region_n == 4'hf && o_eprom_sel_n && o_sram_sel_n)
    else $error("memory select in io cycle");
  a_mem_no_io: assert property (!io_m |->
    o_io_region_n == 4'hf && o_keypad_sel_n && o_serial_sel_n && o_expan_io_sel_n)
    else $error("io select in memory cycle");
  a_mem_region: assert property (!io_m |-> $onehot(~o_mem_region_n) &&
    !o_mem_region_n[{o_addr[15], o_addr[14] & !o_map_alt}])
    else $error("memory region wrong");
  a_io_quarter: assert property (io_m |-> $onehot(~o_io_region_n) && !o_io_region_n[o_addr[7:6]])
    else $error("io quarter wrong");
  a_eprom_map: assert property (!io_m |->
    o_eprom_sel_n == (o_map_alt ? o_addr[15] : |o_addr[15:14]))
    else $error("program store select wrong");
  a_sram_map: assert property (!io_m |->
    o_sram_sel_n == (o_map_alt ? !o_addr[15] : o_addr[15] == o_addr[14]))
    else $error("static ram select wrong");
  a_combo_dual: assert property (o_combo_peripheral_select_n ==
    !((!io_m && !o_map_alt && &o_addr[15:14]) || (io_m && o_addr[7:6] == 2'b00)))
    else $error("peripheral select wrong");
  a_io_selects: assert property (io_m |-> {o_keypad_sel_n, o_serial_sel_n, o_expan_io_sel_n} ==
    ~{o_addr[7:6] == 2'b01, o_addr[7:6] == 2'b10, o_addr[7:6] == 2'b11})
    else $error("io device select wrong");
endmodule

// ### trainer_address_decoder_tb_top.sv
module trainer_address_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst, i_req, i_io, i_write, jumper, o_ready, o_done, o_io_cycle, o_map_alt;
  logic e_n, s_n, c_n, k_n, u_n, x_n, exp_io, exp_wr, exp_alt;
  logic [15:0] i_addr, o_addr, exp_addr;
  logic [7:0] i_wdata, o_rdata, exp_wdata;
  logic [3:0] mreg_n, ireg_n;
  logic [15:0] bnd [8] = '{16'h0000, 16'h3fff, 16'h4000, 16'h7fff,
                           16'h8000, 16'hbfff, 16'hc000, 16'hffff};
  int n_mismatch, checks_done;
  logic [7:0] rd_q [$];
  tad_bus_if bus_if ();
  tad_cpu_end tad_cpu_end_i (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_io(i_io),
    .i_write(i_write), .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready),
    .o_done(o_done), .o_rdata(o_rdata), .bus(bus_if));
  tad_decoder tad_decoder_i (.i_clk(i_clk), .i_rst(i_rst), .i_memory_map_jumper(jumper),
    .bus(bus_if), .o_addr(o_addr), .o_io_cycle(o_io_cycle), .o_eprom_sel_n(e_n),
    .o_sram_sel_n(s_n), .o_combo_peripheral_select_n(c_n), .o_keypad_sel_n(k_n),
    .o_serial_sel_n(u_n), .o_expan_io_sel_n(x_n), .o_mem_region_n(mreg_n),
    .o_io_region_n(ireg_n), .o_map_alt(o_map_alt));
  tad_dec_sva chk_i (.i_clk(i_clk), .i_rst(i_rst), .muxed_addr_data(bus_if.muxed_addr_data),
    .high_addr_byte(bus_if.high_addr_byte), .ale(bus_if.ale), .rd_n(bus_if.rd_n),
    .io_m(bus_if.io_m), .o_addr(o_addr), .o_map_alt(o_map_alt), .o_eprom_sel_n(e_n),
    .o_sram_sel_n(s_n), .o_combo_peripheral_select_n(c_n), .o_keypad_sel_n(k_n),
    .o_serial_sel_n(u_n), .o_expan_io_sel_n(x_n), .o_mem_region_n(mreg_n),
    .o_io_region_n(ireg_n));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  function automatic logic [7:0] mem_f(input logic [15:0] a);
    return a[7:0] ^ {a[14:8], a[15]} ^ 8'h5a;
  endfunction

  // Select model, order {eprom, sram, combo, keypad, serial, expansion}, active low.
  function automatic logic [5:0] sel_f(input logic [15:0] a, input logic io, input logic alt);
    int m;
    int p;
    m = io ? -1 : (alt ? 2 * a[15] : int'(a[15:14]));
    p = io ? int'(a[7:6]) : -1;
    return ~{m == 0, m == 1 || m == 2, m == 3 || p == 0, p == 1, p == 2, p == 3};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // The memory or I/O chip answers while the read strobe is low.
  always @(posedge i_clk) begin
    bus_if.ext_oe_n <= i_rst || bus_if.rd_n;
    bus_if.ext_data <= mem_f(o_addr);
  end

  always @(negedge i_clk) begin
    if (!i_rst && (bus_if.rd_n === 1'b0 || bus_if.wr_n === 1'b0)) begin
      check(o_addr, exp_addr);
      check(16'({e_n, s_n, c_n, k_n, u_n, x_n}), 16'(sel_f(exp_addr, exp_io, exp_alt)));
      check(16'(o_io_cycle), 16'(exp_io));
      if (exp_wr) check(16'(bus_if.muxed_addr_data), 16'(exp_wdata));
    end
  end

  task automatic wait_ready();
    int n;
    n = 0;
    while (o_ready !== 1'b1 && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
    if (o_ready !== 1'b1) n_mismatch++;
  endtask

  task automatic xfer(input logic io, input logic wr, input logic [15:0] a,
                      input logic [7:0] d);
    int n;
    bit in_span;
    wait_ready();
    @(posedge i_clk);
    i_req <= 1'b1;
    i_io <= io;
    i_write <= wr;
    i_addr <= a;
    i_wdata <= d;
    exp_io = io;
    exp_wr = wr;
    exp_wdata = d;
    exp_addr = io ? {a[7:0], a[7:0]} : a;
    if (!wr) rd_q.push_back(mem_f(exp_addr));
    @(posedge i_clk);
    i_req <= 1'b0;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_done !== 1'b1 && n < 1000);
    check(16'(o_done), 16'h0001);
    in_span = n >= tad_pkg::CYCLE_T_MIN * 2 * tad_pkg::HALF_T_CYC;
    in_span = in_span && n <= (tad_pkg::CYCLE_T_MAX + 1) * 2 * tad_pkg::HALF_T_CYC;
    check(16'(in_span), 16'h0001);
    if (!wr) check(16'(o_rdata), 16'(rd_q.pop_front()));
  endtask

  task automatic set_map(input logic v);
    @(posedge i_clk);
    jumper <= v;
    repeat (4) @(posedge i_clk);
    exp_alt = v;
    check(16'(o_map_alt), 16'(v));
  endtask

  initial begin
    repeat (60000) @(posedge i_clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    i_rst = 1'b1;
    i_req = 1'b0;
    i_io = 1'b0;
    i_write = 1'b0;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    jumper = 1'b0;
    {exp_addr, exp_io, exp_wr, exp_alt, exp_wdata} = '0;
    n_mismatch = 0;
    checks_done = 0;
    void'($urandom(29));
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    wait_ready();
    check(16'(o_rdata), 16'(mem_f(16'h0000)));
    for (int m = 0; m < 2; m++) begin
      set_map(1'(m));
      for (int i = 0; i < 8; i++) begin
        xfer(1'b0, 1'(i), bnd[i], 8'(i * 37));
        xfer(1'b1, 1'(i + 1), {8'($urandom), bnd[i][15:8]}, 8'($urandom));
      end
    end
    repeat (40) begin
      set_map(1'($urandom_range(0, 1)));
      xfer(1'($urandom_range(0, 1)), 1'($urandom_range(0, 1)), 16'($urandom), 8'($urandom));
    end
    report_and_stop();
  end
endmodule
